// [wrc_defs.svh]
`ifndef WRC_DEFS_SVH
`define WRC_DEFS_SVH

// command byte encodings
`define WRC_CMD_VOL_WRITE    8'h11
`define WRC_CMD_STORE_WRITE  8'h21
`define WRC_CMD_RECALL       8'h61
`define WRC_CMD_SAVE         8'h51

// fixed upper address nibble
`define WRC_ADDR_HI          4'h5

// data byte field: wiper position bits
`define WRC_POS_MSB          7
`define WRC_POS_LSB          3

// reset values
`define WRC_STORE_RST        5'h00
`define WRC_WIPER_RST        5'h00

// timing
`define WRC_CLK_NS           25
`define WRC_T_INIT_US        20
`define WRC_INIT_CYC         ((`WRC_T_INIT_US * 1000) / `WRC_CLK_NS)
`define WRC_T_STORE_MS       12
`define WRC_STORE_CYC        ((`WRC_T_STORE_MS * 1000000 + `WRC_CLK_NS - 1) / `WRC_CLK_NS)

`endif

// [wrc_pkg.sv]
package wrc_pkg;

    typedef enum logic [4:0] {
        WRC_L_IDLE = 5'b00001,
        WRC_L_ADDR = 5'b00010,
        WRC_L_CMD  = 5'b00100,
        WRC_L_DATA = 5'b01000,
        WRC_L_FULL = 5'b10000
    } wrc_lstate_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } wrc_frame_t;

endpackage : wrc_pkg

// [wrc_decoder.sv]
`timescale 1ns/1ps
`include "wrc_defs.svh"

// Operation
// - decode command byte to choose operation
// - wiper position from data bits 7..3
// - data bits 2..0 are ignored
// - volatile write loads wiper immediately
// - store write leaves wiper unchanged
// - recall copies store into wiper
// - save copies wiper into store
// - four fixed command byte encodings
// - five-bit store kept across power loss
// - store starts as all zeros
// - power-up copies store into wiper
// - power-up recall done within 20 us
// - standby once ready, whenever no transaction or store write runs
// - start, address, command, data, stop
// - flag low writes, high is no-op
// - address upper nibble fixed at 0101
// - acknowledge by pulling data low, ninth clock
module wrc_decoder
    import wrc_pkg::*;
#(
    parameter logic fixed_address_bit_high = 1'b0,
    parameter logic fixed_address_bit_mid  = 1'b0,
    parameter int   STORE_CYC              = `WRC_STORE_CYC
) (
    // system
    input  wire logic       clk,
    input  wire logic       srst,
    // serial link
    input  wire logic       lclk,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       address_select_input,
    // wiper and status
    output logic [4:0]      wiper,
    output logic            ready,
    output logic            standby,
    output logic            store_busy
);

    // ---------------- link domain ----------------
    logic        lrst_m, lrst;
    logic        scl_m, scl_s, scl_d;
    logic        sda_m, sda_s, sda_d;
    logic        asel_m, asel_s;
    wrc_lstate_t lstate;
    logic [3:0]  bits;
    logic [7:0]  shreg;
    logic        ack_want;
    wrc_frame_t  frame;
    logic        req_tgl;
    logic        link_busy;
    logic [7:0]  byte_in;
    logic        scl_rise, scl_fall, start_c, stop_c;

    always_ff @(posedge lclk) begin
        lrst_m <= srst;
        lrst   <= lrst_m;
    end

    always_ff @(posedge lclk) begin
        scl_m  <= scl_in;
        scl_s  <= scl_m;
        scl_d  <= scl_s;
        sda_m  <= sda_in;
        sda_s  <= sda_m;
        sda_d  <= sda_s;
        asel_m <= address_select_input;
        asel_s <= asel_m;
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
    assign byte_in  = {shreg[6:0], sda_s};

    always_ff @(posedge lclk) begin
        if (lrst) begin
            lstate    <= WRC_L_IDLE;
            bits      <= 4'h0;
            shreg     <= 8'h00;
            ack_want  <= 1'b0;
            frame     <= '0;
            req_tgl   <= 1'b0;
            link_busy <= 1'b0;
        end else begin
            link_busy <= (lstate != WRC_L_IDLE);
            if (start_c) begin
                lstate   <= WRC_L_ADDR;
                bits     <= 4'h0;
                ack_want <= 1'b0;
            end else if (stop_c) begin
                // hand the frame over only once both bytes were taken
                if (lstate == WRC_L_FULL) begin
                    req_tgl <= ~req_tgl;
                end
                lstate <= WRC_L_IDLE;
            // an ack owed after a no-op address must still count its ninth clock,
            // or the data line would stay pulled low and hide the stop
            end else if (scl_rise && (lstate != WRC_L_IDLE || bits == 4'h8)) begin
                if (bits == 4'h8) begin
                    bits <= 4'h0;
                end else begin
                    shreg <= byte_in;
                    bits  <= bits + 4'h1;
                end
                if (bits == 4'h7) begin
                    ack_want <= 1'b0;
                    case (lstate)
                        WRC_L_ADDR: begin
                            if (byte_in[7:1] == {`WRC_ADDR_HI, fixed_address_bit_high,
                                                 fixed_address_bit_mid, asel_s}) begin
                                ack_want <= 1'b1;
                                // flag high: acked but nothing follows
                                lstate   <= byte_in[0] ? WRC_L_IDLE : WRC_L_CMD;
                            end else begin
                                lstate <= WRC_L_IDLE;
                            end
                        end
                        WRC_L_CMD: begin
                            frame.cmd <= byte_in;
                            ack_want  <= 1'b1;
                            lstate    <= WRC_L_DATA;
                        end
                        WRC_L_DATA: begin
                            frame.data <= byte_in;
                            ack_want   <= 1'b1;
                            lstate     <= WRC_L_FULL;
                        end
                        default: begin
                            ack_want <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // ack window opens after the eighth falling edge, closes after the ninth
    always_ff @(posedge lclk) begin
        if (lrst) begin
            sda_oe_n <= 1'b1;
            sda_out  <= 1'b0;
        end else if (start_c || stop_c) begin
            sda_oe_n <= 1'b1;
        end else if (scl_fall && bits == 4'h8 && ack_want) begin
            sda_oe_n <= 1'b0;
        end else if (scl_fall && bits == 4'h0) begin
            sda_oe_n <= 1'b1;
        end
    end

    // ---------------- system domain ----------------
    logic        tg_m, tg_s, tg_d;
    logic        busy_m, busy_s;
    logic        go;
    wrc_frame_t  fr;
    logic [9:0]  init_cnt;
    logic        init_load;
    logic [19:0] store_cnt;
    logic [4:0]  store = `WRC_STORE_RST;
    logic        is_vol, is_nv, is_rec, is_save;

    always_ff @(posedge clk) begin
        tg_m   <= req_tgl;
        tg_s   <= tg_m;
        tg_d   <= tg_s;
        busy_m <= link_busy;
        busy_s <= busy_m;
    end

    // frame is stable until the next command byte is taken after the toggle moves
    always_ff @(posedge clk) begin
        if (srst) begin
            go <= 1'b0;
            fr <= '0;
        end else begin
            go <= ready & (tg_s ^ tg_d);
            if (tg_s ^ tg_d) begin
                fr <= frame;
            end
        end
    end

    assign is_vol  = fr.cmd == `WRC_CMD_VOL_WRITE;
    assign is_nv   = fr.cmd == `WRC_CMD_STORE_WRITE;
    assign is_rec  = fr.cmd == `WRC_CMD_RECALL;
    assign is_save = fr.cmd == `WRC_CMD_SAVE;

    always_ff @(posedge clk) begin
        if (srst) begin
            init_cnt  <= 10'h000;
            init_load <= 1'b0;
            ready     <= 1'b0;
        end else begin
            init_load <= 1'b0;
            if (!ready) begin
                init_cnt <= init_cnt + 10'h001;
                if (init_cnt == 10'(`WRC_INIT_CYC - 2)) begin
                    init_load <= 1'b1;
                    ready     <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wiper <= `WRC_WIPER_RST;
        end else if (init_load) begin
            wiper <= store;
        end else if (go) begin
            if (is_vol) begin
                wiper <= fr.data[`WRC_POS_MSB:`WRC_POS_LSB];
            end else if (is_rec) begin
                wiper <= store;
            end
        end
    end

    // no reset: contents survive like the nonvolatile cell
    always_ff @(posedge clk) begin
        if (go && is_nv) begin
            store <= fr.data[`WRC_POS_MSB:`WRC_POS_LSB];
        end else if (go && is_save) begin
            store <= wiper;
        end
    end

    // write-cycle time of the store; the master must stay quiet meanwhile
    always_ff @(posedge clk) begin
        if (srst) begin
            store_cnt  <= 20'h00000;
            store_busy <= 1'b0;
        end else if (go && (is_nv || is_save)) begin
            store_cnt  <= 20'(STORE_CYC);
            store_busy <= 1'b1;
        end else if (store_cnt != 20'h00000) begin
            store_cnt  <= store_cnt - 20'h00001;
            store_busy <= (store_cnt != 20'h00001);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            standby <= 1'b0;
        end else begin
            standby <= ready & ~busy_s & ~go & ~store_busy;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_vol;
        go && is_vol |=> wiper == $past(fr.data[7:3]);
    endproperty
    a_vol: assert property (p_vol) else $error("volatile write wrong");

    property p_nv;
        go && is_nv |=> $stable(wiper) && store == $past(fr.data[7:3]);
    endproperty
    a_nv: assert property (p_nv) else $error("store write wrong");

    property p_rec;
        go && is_rec |=> wiper == $past(store);
    endproperty
    a_rec: assert property (p_rec) else $error("recall wrong");

    property p_save;
        go && is_save |=> store == $past(wiper) ##1 store_busy;
    endproperty
    a_save: assert property (p_save) else $error("save wrong");

    property p_unk;
        go && !(is_vol || is_nv || is_rec || is_save) |=> $stable(wiper) && $stable(store);
    endproperty
    a_unk: assert property (p_unk) else $error("unknown command acted");

    property p_hold;
        !go && !init_load |=> $stable(wiper);
    endproperty
    a_hold: assert property (p_hold) else $error("wiper moved unprompted");

    property p_pwr;
        $fell(srst) |-> ##[1:800] ready;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power-up recall late");

    property p_pwrval;
        $rose(ready) |=> wiper == $past(store);
    endproperty
    a_pwrval: assert property (p_pwrval) else $error("power-up value wrong");

    property p_sby;
        busy_s |=> !standby;
    endproperty
    a_sby: assert property (p_sby) else $error("standby during transfer");

    property p_ack;
        @(posedge lclk) disable iff (lrst)
        $fell(sda_oe_n) |-> $past(bits) == 4'h8 && !sda_out;
    endproperty
    a_ack: assert property (p_ack) else $error("ack out of place");

    c_vol:  cover property (go && is_vol);
    c_nv:   cover property (go && is_nv);
    c_rec:  cover property (go && is_rec);
    c_save: cover property (go && is_save);

endmodule : wrc_decoder

// [wrc_master.sv]
`timescale 1ns/1ps

module wrc_master (
    // clock
    input  wire logic clk,
    // two-wire bus: sda open drain with pull-up, scl driven directly
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_low
);
    // quarter scl period; scl high lasts 60 clk, well above 4 lclk
    localparam int QTR = 30;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic qwait();
        repeat (QTR) @(posedge clk);
    endtask : qwait

    // data moves only while scl is low
    task automatic clock_bit(input logic b, output logic seen);
        sda_low <= ~b;
        qwait();
        scl <= 1'b1;
        qwait();
        seen = sda_in;
        qwait();
        scl <= 1'b0;
        qwait();
    endtask : clock_bit

    task automatic send(input logic [6:0] a, input logic fl, input logic [7:0] c, d,
                        output int acks);
        logic [7:0] by [3];
        logic       seen;
        by = '{{a, fl}, c, d};
        acks = 0;
        @(posedge clk);
        sda_low <= 1'b1;
        qwait();
        scl <= 1'b0;
        qwait();
        for (int i = 0; i < 3; i++) begin
            for (int j = 7; j >= 0; j--) clock_bit(by[i][j], seen);
            clock_bit(1'b1, seen);
            if (seen === 1'b0) acks++;
        end
        sda_low <= 1'b1;
        qwait();
        scl <= 1'b1;
        qwait();
        sda_low <= 1'b0;
        qwait();
    endtask : send
endmodule : wrc_master

// [wrc_decoder_tb.sv]
`timescale 1ns/1ps
`include "wrc_defs.svh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, e, s); end end

module wrc_decoder_tb;
    import wrc_pkg::*;
    logic       clk, lclk, srst, asel, sda_out, sda_oe_n;
    logic       ready, standby, store_busy, scl, m_low;
    logic [4:0] wiper;
    wire        sda;
    int         n_fail = 0;
    int         n_checks = 0;
    int         n, acks;
    localparam logic [6:0] ADR = {`WRC_ADDR_HI, 3'b000};

    assign sda = !(m_low || (!sda_oe_n && !sda_out));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #7;
        forever #62.5 lclk = ~lclk;
    end

    wrc_decoder #(.STORE_CYC(50)) wrc_decoder_i (.clk(clk), .srst(srst), .lclk(lclk),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_select_input(asel), .wiper(wiper), .ready(ready), .standby(standby),
        .store_busy(store_busy));
    wrc_master wrc_master_i (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(m_low));

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    // hold covers 4 lclk edges as well as 24 clk edges
    task automatic do_reset(input logic [4:0] exp);
        srst <= 1'b1;
        repeat (24) @(posedge clk);
        srst <= 1'b0;
        n = 0;
        // sample on the falling edge, away from the edge that moves ready
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        `CHK("init_time", 1'b1, n > 790 && n < 810)
        // the recalled value lands one clock after ready rises
        repeat (2) @(negedge clk);
        `CHK("wiper_init", exp, wiper)
        repeat (10) @(negedge clk);
        `CHK("standby", 1'b1, standby)
    endtask : do_reset

    task automatic frame(input logic [6:0] a, input logic fl, input logic [7:0] c, d,
                         input int exp_acks);
        wrc_master_i.send(a, fl, c, d, acks);
        if (exp_acks >= 0) `CHK("acks", exp_acks, acks)
        repeat (20) @(posedge clk);
    endtask : frame

    // no new command until the store write has finished
    task automatic wait_busy();
        n = 0;
        while (store_busy !== 1'b0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        `CHK("busy_end", 1'b0, store_busy)
    endtask : wait_busy

    initial begin
        // nine frames of about 3400 clocks each plus two power-up intervals
        repeat (50000) @(posedge clk);
        n_fail++;
        $display("Error watchdog expected done seen hang");
        test_done();
    end

    initial begin
        srst = 1'b1;
        asel = 1'b0;
        do_reset(5'h00);
        frame(ADR, 1'b0, `WRC_CMD_VOL_WRITE, 8'hae, 3);
        `CHK("wiper", 5'h15, wiper)
        frame(ADR, 1'b0, `WRC_CMD_STORE_WRITE, 8'h55, 3);
        `CHK("wiper", 5'h15, wiper)
        `CHK("busy", 1'b1, store_busy)
        `CHK("standby", 1'b0, standby)
        wait_busy();
        frame(ADR, 1'b0, `WRC_CMD_RECALL, 8'hff, 3);
        `CHK("wiper", 5'h0a, wiper)
        frame(ADR, 1'b0, `WRC_CMD_VOL_WRITE, 8'hf8, 3);
        frame(ADR, 1'b0, `WRC_CMD_SAVE, 8'h00, 3);
        `CHK("wiper", 5'h1f, wiper)
        wait_busy();
        frame(ADR, 1'b0, 8'h31, 8'h08, 3);
        `CHK("wiper", 5'h1f, wiper)
        frame(ADR, 1'b1, `WRC_CMD_VOL_WRITE, 8'h00, 1);
        `CHK("wiper", 5'h1f, wiper)
        frame({`WRC_ADDR_HI, 3'b001}, 1'b0, `WRC_CMD_VOL_WRITE, 8'h00, 0);
        `CHK("wiper", 5'h1f, wiper)
        asel <= 1'b1;
        repeat (10) @(posedge clk);
        frame({`WRC_ADDR_HI, 3'b001}, 1'b0, `WRC_CMD_VOL_WRITE, 8'h10, 3);
        `CHK("wiper", 5'h02, wiper)
        do_reset(5'h1f);
        test_done();
    end
endmodule : wrc_decoder_tb
